// *** rtl/lls_pkg.sv ***
package lls_pkg;
    localparam int unsigned TBL_DEPTH = 2048;
    localparam int unsigned TBL_AW    = 11;
    localparam int unsigned TBL_DW    = 8;
    localparam int unsigned LINE_W    = 10;
    localparam int unsigned BUS_DW    = 32;

    // Register index sits in byte address bits 5:2, the board base in bits 9:6.
    localparam int unsigned IDX_LSB   = 2;
    localparam int unsigned BASE_LSB  = 6;
    localparam int unsigned IDX_W     = 4;
    localparam logic [3:0]  IDX_CTRL  = 4'h0;
    localparam logic [3:0]  IDX_STAT  = 4'h1;
    localparam logic [3:0]  IDX_TDATA = 4'h2;

    // Fields of control_reg_zero.
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam int unsigned CTL_CH_LSB  = 0;
    localparam int unsigned CTL_PROG    = 4;
    localparam int unsigned CTL_CRST    = 5;
    localparam int unsigned CTL_SRC_LSB = 6;

    // Fields of the status register.
    localparam int unsigned STAT_CH_LSB = 0;
    localparam int unsigned STAT_FIELD  = 2;
    localparam int unsigned STAT_PROG   = 3;

    // Bits of a line_lookup_table word.
    localparam int unsigned TB_LASER_LSB = 0;
    localparam int unsigned TB_WIN       = 4;
    localparam int unsigned TB_CLAMP     = 5;
    localparam int unsigned TB_CH_LSB    = 6;
    localparam int unsigned TB_IRQ       = 6;

    // Channel source modes.
    localparam logic [1:0] SRC_TABLE   = 2'h0;
    localparam logic [1:0] SRC_BUF     = 2'h1;
    localparam logic [1:0] SRC_BUF_IRQ = 2'h2;
    localparam logic [1:0] SRC_DIRECT  = 2'h3;

    function automatic logic [3:0] chan_mask(input logic [1:0] ch);
        chan_mask = 4'h1 << ch;
    endfunction
endpackage

// *** rtl/lls_ram.sv ***
`timescale 1ns/10ps
`default_nettype none
module lls_ram
    import lls_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              wr_en,
    input  wire logic [TBL_AW-1:0] addr,
    input  wire logic [TBL_DW-1:0] wr_data,
    output logic      [TBL_DW-1:0] rd_data
);
    logic [TBL_DW-1:0] mem [TBL_DEPTH];

    // Read data are registered, so a word appears one edge after its address.
    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule
`default_nettype wire

// *** rtl/lls_top.sv ***
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Table of 2048 eight-bit words.
// - Acquisition address is field plus line count.
// - Fields start at address 0 or 1024.
// - Line restart pulse advances line count.
// - Frame restart pulse clears line count.
// - Four laser waveforms change per line.
// - One table bit forms the processing window.
// - One table bit gates the restore clamp.
// - Programming counter steps per table access.
// - Programming counter only clears, never loads.
// - Writing 11 selects programming, counter zero.
// - Clearing bit five lets counter advance.
// - Setting bit five forces counter zero.
// - Writing 00 returns to acquisition mode.
// - Polarity strap picks laser active level.
// - Low nibble selects register, high matches base.
// - Base straps read zero when fitted.
// - Source mode picks channel or interrupt bit.
// - Unselected laser outputs stay inactive.
module lls_top
    import lls_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [BUS_DW-1:0] paddr,
    input  wire logic [BUS_DW-1:0] pwdata,
    output logic      [BUS_DW-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              line_restart_n,
    input  wire logic              frame_restart_n,
    input  wire logic              field_id,
    input  wire logic [3:0]        base_strap,
    input  wire logic              laser_pol_strap,
    output logic      [3:0]        laser_mod,
    output logic                   process_window_n,
    output logic                   clamp_enable,
    output logic      [1:0]        channel_sel,
    output logic                   line_event_irq
);
    logic [3:0]        base_r;
    logic              pol_r;
    logic [7:0]        ctrl_r;
    logic [TBL_AW-1:0] prog_cnt_r;
    logic [LINE_W-1:0] line_cnt_r;
    logic              line_q_r;
    logic              frame_q_r;
    logic              ev1_r;
    logic              ev2_r;
    logic [TBL_DW-1:0] tbl_word_r;
    logic [1:0]        chan_r;
    logic [1:0]        chan_nxt;
    logic [3:0]        laser_r;
    logic              win_n_r;
    logic              clamp_r;
    logic              irq_r;
    logic              pready_r;
    logic              pslverr_r;
    logic [BUS_DW-1:0] prdata_r;
    logic [BUS_DW-1:0] rd_mux;
    logic [IDX_W-1:0]  bus_idx;
    logic              bus_hit;
    logic              bus_acc;
    logic              bus_done;
    logic              ctrl_wr;
    logic              tbl_acc;
    logic              prog;
    logic              cnt_clr;
    logic              line_pulse;
    logic              frame_pulse;
    logic [1:0]        src;
    logic [TBL_AW-1:0] tbl_addr;
    logic              tbl_wr;
    logic [TBL_DW-1:0] tbl_rd;
    logic [7:0]        stat;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Straps are sampled while reset is held, so a strap change needs a reset.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            base_r <= base_strap;
            pol_r  <= laser_pol_strap;
        end
    end

    assign bus_idx  = paddr[IDX_LSB +: IDX_W];
    assign bus_hit  = paddr[BASE_LSB +: IDX_W] == base_r;
    assign bus_acc  = psel & penable & bus_hit;
    assign bus_done = bus_acc & pready_r;
    assign ctrl_wr  = bus_done & pwrite & (bus_idx == IDX_CTRL);
    assign tbl_acc  = bus_done & (bus_idx == IDX_TDATA);

    assign prog    = ctrl_r[CTL_PROG];
    assign src     = ctrl_r[CTL_SRC_LSB +: 2];
    assign cnt_clr = ctrl_r[CTL_CRST] | (ctrl_wr & pwdata[CTL_CRST]);

    assign stat = {4'h0, prog, field_id, chan_r};

    always_comb
    begin
        rd_mux = {BUS_DW{1'b0}};
        case (bus_idx)
            IDX_CTRL:  rd_mux[TBL_DW-1:0] = ctrl_r;
            IDX_STAT:  rd_mux[TBL_DW-1:0] = stat;
            IDX_TDATA: rd_mux[TBL_DW-1:0] = tbl_rd;
            default:   rd_mux = {BUS_DW{1'b0}};
        endcase
    end

    // Every access to this board takes one wait state; foreign bases get nothing.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= {BUS_DW{1'b0}};
        end
        else
        begin
            pready_r  <= bus_acc & ~pready_r;
            pslverr_r <= bus_acc & ~pready_r & (bus_idx > IDX_TDATA);
            prdata_r  <= (bus_acc & ~pready_r & ~pwrite) ? rd_mux : {BUS_DW{1'b0}};
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ctrl_r <= CTRL_RST;
        end
        else if (ctrl_wr)
        begin
            ctrl_r <= pwdata[TBL_DW-1:0];
        end
    end

    // The counter has no load path: software can only clear it and step it.
    always_ff @(posedge clock)
    begin
        if (rst || cnt_clr)
        begin
            prog_cnt_r <= '0;
        end
        else if (prog && tbl_acc)
        begin
            prog_cnt_r <= prog_cnt_r + 1'b1;
        end
    end

    // Restart inputs are synchronous; a pulse is the falling edge of the level.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            line_q_r  <= 1'b1;
            frame_q_r <= 1'b1;
        end
        else
        begin
            line_q_r  <= line_restart_n;
            frame_q_r <= frame_restart_n;
        end
    end

    assign line_pulse  = line_q_r & ~line_restart_n;
    assign frame_pulse = frame_q_r & ~frame_restart_n;

    // The line counter holds while programming so acquisition resumes cleanly.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            line_cnt_r <= '0;
        end
        else if (!prog)
        begin
            if (frame_pulse)
            begin
                line_cnt_r <= '0;
            end
            else if (line_pulse)
            begin
                line_cnt_r <= line_cnt_r + 1'b1;
            end
        end
    end

    assign tbl_addr = prog ? prog_cnt_r : {field_id, line_cnt_r};
    assign tbl_wr   = prog & tbl_acc & pwrite;

    lls_ram u_ram
    (
        .clock   (clock),
        .wr_en   (tbl_wr),
        .addr    (tbl_addr),
        .wr_data (pwdata[TBL_DW-1:0]),
        .rd_data (tbl_rd)
    );

    // The word is taken two edges after an acquisition line or frame event, once
    // the RAM has read the new address, so the table word changes only on line boundaries.
    // A field change or a return from programming waits for the next event.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ev1_r      <= 1'b0;
            ev2_r      <= 1'b0;
            tbl_word_r <= {TBL_DW{1'b0}};
        end
        else
        begin
            ev1_r <= (line_pulse | frame_pulse) & ~prog;
            ev2_r <= ev1_r & ~prog;
            if (ev2_r)
            begin
                tbl_word_r <= tbl_rd;
            end
        end
    end

    always_comb
    begin
        chan_nxt = chan_r;
        unique case (src)
            SRC_TABLE:
            begin
                chan_nxt = tbl_word_r[TB_CH_LSB +: 2];
            end
            SRC_BUF, SRC_BUF_IRQ:
            begin
                if (frame_pulse)
                begin
                    chan_nxt = ctrl_r[CTL_CH_LSB +: 2];
                end
            end
            SRC_DIRECT:
            begin
                chan_nxt = ctrl_r[CTL_CH_LSB +: 2];
            end
        endcase
    end

    // Reset drives the lasers to the idle level of the strap seen at that edge.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            chan_r  <= 2'h0;
            laser_r <= {4{~laser_pol_strap}};
            win_n_r <= 1'b1;
            clamp_r <= 1'b0;
            irq_r   <= 1'b0;
        end
        else
        begin
            chan_r  <= chan_nxt;
            laser_r <= (tbl_word_r[TB_LASER_LSB +: 4] & chan_mask(chan_nxt))
                       ^ {4{~pol_r}};
            win_n_r <= ~tbl_word_r[TB_WIN];
            clamp_r <= tbl_word_r[TB_CLAMP];
            irq_r   <= (src == SRC_BUF_IRQ) & tbl_word_r[TB_IRQ];
        end
    end

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign laser_mod        = laser_r;
    assign process_window_n = win_n_r;
    assign clamp_enable     = clamp_r;
    assign channel_sel      = chan_r;
    assign line_event_irq   = irq_r;

    sequence s_setup;
        psel && !penable && bus_hit;
    endsequence

    sequence s_access;
        psel && penable;
    endsequence

    a_bus_wait_state: assert property (
        s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("register access not answered after one wait state");

    a_foreign_silent: assert property (
        psel && !bus_hit |=> !pready)
    else $error("foreign base cycle was acknowledged");

    a_line_step: assert property (
        !prog && !frame_pulse && line_pulse |=> line_cnt_r == $past(line_cnt_r) + 1'b1)
    else $error("line counter did not step on line restart");

    a_frame_clear: assert property (
        !prog && frame_pulse |=> line_cnt_r == '0 && tbl_addr == {field_id, {LINE_W{1'b0}}})
    else $error("frame restart did not clear line counter");

    a_prog_select: assert property (
        ctrl_wr && pwdata[CTL_CRST] && pwdata[CTL_PROG] |=> prog && prog_cnt_r == '0 [*2])
    else $error("programming select did not hold counter at zero");

    a_prog_clear: assert property (
        ctrl_r[CTL_CRST] |-> prog_cnt_r == '0)
    else $error("programming counter not held at zero");

    a_prog_step: assert property (
        prog && !cnt_clr && tbl_acc |=> prog_cnt_r == $past(prog_cnt_r) + 1'b1)
    else $error("programming counter did not step on table access");

    a_prog_quiet: assert property (
        prog && !cnt_clr && !tbl_acc |=> $stable(prog_cnt_r))
    else $error("programming counter moved without table access");

    a_acq_return: assert property (
        ctrl_wr && pwdata[CTL_PROG +: 2] == 2'h0 |=> !prog ##0 tbl_addr == {field_id, line_cnt_r})
    else $error("acquisition mode not restored");

    a_laser_idle: assert property (
        ((laser_mod ^ {4{~pol_r}}) & ~chan_mask(channel_sel)) == 4'h0)
    else $error("unselected laser output not idle");

    a_word_hold: assert property (
        !ev2_r |=> $stable(tbl_word_r))
    else $error("table word changed off a line boundary");

    a_window_follow: assert property (
        process_window_n == !$past(tbl_word_r[TB_WIN]))
    else $error("processing window does not follow its table bit");

    a_irq_gate: assert property (
        src != SRC_BUF_IRQ |=> !line_event_irq)
    else $error("line event raised outside its source mode");
endmodule
`default_nettype wire

// *** bench/lls_bus_master.sv ***
`timescale 1ns/10ps
`default_nettype none
module lls_bus_master
    import lls_pkg::*;
(
    input  wire logic              clock,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [BUS_DW-1:0] paddr,
    output logic      [BUS_DW-1:0] pwdata,
    input  wire logic [BUS_DW-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end

    function automatic logic [7:0] word(input int i);
        logic [10:0] a;
        a = 11'(i);
        return {a[10], a[10] ^ a[9], a[5:0] ^ 6'h2a};
    endfunction

    // The wait has no limit of its own; the bench's cycle ceiling ends a hang.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output int waits);
        waits = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
        begin
            @(posedge clock);
            waits++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show the inverse so a stale value is never trusted.
        paddr <= ~a;
        pwdata <= ~wd;
    endtask

    // A foreign base is never answered, so the access is held for a fixed span.
    task automatic probe(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                         output logic seen);
        seen = 1'b0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        repeat (4)
        begin
            @(posedge clock);
            if (pready !== 1'b0)
            begin
                seen = 1'b1;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~wd;
    endtask

    task automatic load_table();
        logic [31:0] r;
        logic        e;
        int          n;
        xfer(1'b1, 32'h0, 32'h30, r, e, n);
        xfer(1'b1, 32'h0, 32'h10, r, e, n);
        for (int i = 0; i < TBL_DEPTH; i++)
            xfer(1'b1, 32'h8, {24'h0, word(i)}, r, e, n);
    endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import lls_pkg::*;
;
    logic              clock;
    logic              rst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [BUS_DW-1:0] paddr;
    logic [BUS_DW-1:0] pwdata;
    logic [BUS_DW-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              line_restart_n;
    logic              frame_restart_n;
    logic              field_id;
    logic              laser_pol_strap;
    logic [3:0]        base_strap;
    logic [3:0]        laser_mod;
    logic              process_window_n;
    logic              clamp_enable;
    logic [1:0]        channel_sel;
    logic              line_event_irq;
    int                err_count;
    int                checks_done;
    int                cycles;
    logic [7:0]        v;

    lls_top lls_top_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_restart_n(line_restart_n),
        .frame_restart_n(frame_restart_n), .field_id(field_id),
        .base_strap(base_strap), .laser_pol_strap(laser_pol_strap),
        .laser_mod(laser_mod), .process_window_n(process_window_n),
        .clamp_enable(clamp_enable), .channel_sel(channel_sel),
        .line_event_irq(line_event_irq));

    lls_bus_master bm_i (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    always #12.5 clock = ~clock;

    task automatic finish_test();
        if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            err_count++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic acc(input logic wr, input logic [31:0] a, input logic [7:0] d,
                       output logic [7:0] rv);
        logic [31:0] r;
        logic        e;
        int          n;
        bm_i.xfer(wr, a, {24'h0, d}, r, e, n);
        rv = r[7:0];
        chk("waits", 8'(n), 8'h01);
        chk("pslverr", {7'h0, e}, {7'h0, a[5:2] > 4'h2});
    endtask

    task automatic evt(input logic fr);
        @(posedge clock);
        if (fr)
            frame_restart_n <= 1'b0;
        else
            line_restart_n <= 1'b0;
        @(posedge clock);
        frame_restart_n <= 1'b1;
        line_restart_n <= 1'b1;
        repeat (5) @(posedge clock);
    endtask

    task automatic outs(input int a, input logic [1:0] ch, input logic irq);
        logic [7:0] w;
        logic [3:0] lz;
        w = bm_i.word(a);
        lz = (w[3:0] & (4'h1 << ch)) ^ {4{~laser_pol_strap}};
        chk("laser", 8'(laser_mod), 8'(lz));
        chk("window", {7'h0, process_window_n}, {7'h0, ~w[4]});
        chk("clamp", {7'h0, clamp_enable}, {7'h0, w[5]});
        chk("channel", {6'h0, channel_sel}, {6'h0, ch});
        chk("irq", {7'h0, line_event_irq}, {7'h0, irq & w[6]});
    endtask

    task automatic t_prog();
        bm_i.load_table();
        acc(1'b1, 32'h0, 8'h30, v);
        acc(1'b1, 32'h0, 8'h10, v);
        for (int i = 0; i < TBL_DEPTH; i++)
        begin
            acc(1'b0, 32'h8, 8'h0, v);
            chk("table", v, bm_i.word(i));
        end
        acc(1'b0, 32'h8, 8'h0, v);
        chk("wrap", v, bm_i.word(0));
        acc(1'b0, 32'h4, 8'h0, v);
        chk("status", v & 8'h08, 8'h08);
        acc(1'b1, 32'h0, 8'h30, v);
        acc(1'b0, 32'h8, 8'h0, v);
        acc(1'b0, 32'h8, 8'h0, v);
        chk("cleared", v, bm_i.word(0));
        acc(1'b1, 32'h0, 8'h00, v);
    endtask

    task automatic t_decode();
        logic s;
        bm_i.probe(1'b1, 32'h40, 32'h30, s);
        chk("foreign ack", {7'h0, s}, 8'h00);
        acc(1'b0, 32'h4, 8'h0, v);
        chk("foreign", v & 8'h08, 8'h00);
        acc(1'b0, 32'h14, 8'h0, v);
        chk("unmapped", v, 8'h00);
    endtask

    task automatic t_acq();
        evt(1'b1);
        outs(0, 2'h0, 1'b0);
        evt(1'b0);
        evt(1'b0);
        outs(2, 2'h0, 1'b0);
        field_id <= 1'b1;
        evt(1'b1);
        evt(1'b0);
        outs(1025, 2'h3, 1'b0);
        acc(1'b1, 32'h0, 8'hc2, v);
        repeat (2) @(posedge clock);
        outs(1025, 2'h2, 1'b0);
        acc(1'b1, 32'h0, 8'h40, v);
        evt(1'b0);
        outs(1026, 2'h2, 1'b0);
        evt(1'b1);
        evt(1'b0);
        outs(1025, 2'h0, 1'b0);
        acc(1'b1, 32'h0, 8'h81, v);
        evt(1'b1);
        evt(1'b0);
        outs(1025, 2'h1, 1'b1);
    endtask

    task automatic t_pol();
        logic s;
        laser_pol_strap <= 1'b1;
        base_strap <= 4'h5;
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk("idle", 8'(laser_mod), 8'h00);
        evt(1'b1);
        evt(1'b0);
        outs(1025, 2'h3, 1'b0);
        acc(1'b0, 32'h144, 8'h0, v);
        chk("base", v, 8'h07);
        bm_i.probe(1'b0, 32'h4, 32'h0, s);
        chk("old base", {7'h0, s}, 8'h00);
    endtask

    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        line_restart_n = 1'b1;
        frame_restart_n = 1'b1;
        field_id = 1'b0;
        laser_pol_strap = 1'b0;
        base_strap = 4'h0;
        err_count = 0;
        checks_done = 0;
        cycles = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk("idle", 8'(laser_mod), 8'h0f);
        chk("window", {7'h0, process_window_n}, 8'h01);
        t_prog();
        t_decode();
        t_acq();
        t_pol();
        finish_test();
    end
endmodule
`default_nettype wire
